// file: bench/step_driver_model.sv
// Purpose: far-side driver that also pulses the external trigger pin
// Assumes: pin idles low; pulse length set per request
// Notes: a pulse is high for i_len sampling edges after i_fire
`timescale 1ns/1ps
module step_driver_model (
  input wire logic i_sys_clk,
  input wire logic i_fire,
  input wire logic [3:0] i_len,
  output logic o_trigger_pin
);
  logic [3:0] cnt_ff = 4'h0;
  always_ff @(posedge i_sys_clk) begin
    if (i_fire) begin
      cnt_ff <= i_len;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  // short pulses let the bench probe the sampling filter
  assign o_trigger_pin = (cnt_ff != 4'h0);
endmodule

// file: bench/tb.sv
// Purpose: self-checking bench for the timed pattern output unit
// Assumes: register port strobes one cycle; read data next cycle
// Notes: integer model of buffers, latch and registers
`timescale 1ns/1ps
module tb;
  logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic tm4 = 0, tm5 = 0, fire = 0, trg;
  logic [2:0] i_sel = 3'h0;
  logic [3:0] len = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_pins, o_port_latch;
  int num_errors = 0, n_compared = 0, cyc = 0;
  integer seed = 32'h7a63c8dc;
  int hi = 0, lo = 0, pfs = 0, ctl = 0, pl = 0, lat = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  timed_pattern_output dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_sel(i_sel), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_timer4_match_event(tm4),
    .i_timer5_match_event(tm5), .i_ext_trigger_pin(trg),
    .o_pattern_output_pins(o_pins), .o_port_latch(o_port_latch));
  step_driver_model drv (.i_sys_clk(i_sys_clk), .i_fire(fire),
    .i_len(len), .o_trigger_pin(trg));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] s, logic [7:0] d);
    @(posedge i_sys_clk);
    i_sel <= s;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    if (s < 2 && ctl[5]) begin
      hi = d[7:4];
      lo = d[3:0];
    end else if (s == 0) lo = d[3:0];
    else if (s == 1) hi = d[7:4];
    else if (s == 2) pfs = d;
    else if (s == 3) ctl = d & 8'hF0;
    else if (s == 4) pl = (pl & pfs) | (d & ~pfs);
  endtask
  task automatic rd(logic [2:0] s);
    logic [7:0] e;
    e = 8'(s < 2 ? ((hi << 4 | lo) & pfs) : s == 2 ? pfs :
      s == 3 ? ctl : s == 4 ? pl : 0);
    @(posedge i_sys_clk);
    i_sel <= s;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    check("rdata", e, o_rdata);
    check("port_latch", 8'(pl), o_port_latch);
  endtask
  task automatic pins();
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("pins", 8'(ctl[7] ? lat & pfs : 0), o_pins);
  endtask
  // src 0 timer 4, 1 timer 5, 2 external pin pulsed for n edges
  task automatic fire_src(int src, logic [3:0] n);
    int h, l;
    l = ctl[4] ? src == 2 : src == 0;
    h = ctl[5] ? l : (ctl[4] ? src == 0 : src == 1);
    if (src == 2 && n < 3) begin
      l = 0;
      h = 0;
    end
    @(posedge i_sys_clk);
    tm4 <= (src == 0);
    tm5 <= (src == 1);
    fire <= (src == 2);
    len <= n;
    @(posedge i_sys_clk);
    tm4 <= 1'b0;
    tm5 <= 1'b0;
    fire <= 1'b0;
    // falling edge select needs the pulse end plus three samples
    repeat (10) @(posedge i_sys_clk);
    if (ctl[7] && h) lat = (lat & 8'h0F) | (hi << 4);
    if (ctl[7] && l) lat = (lat & 8'hF0) | lo;
    pins();
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int s = 0; s < 6; s++) rd(3'(s));
    pins();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(3, 8'($random(seed)) & 8'h7F);
      wr(2, 8'($random(seed)));
      wr(4, 8'($random(seed)));
      wr(3'(i & 1), 8'($random(seed)));
      for (int s = 0; s < 6; s++) rd(3'(s));
    end
    $display("test registers done");
    // m bits 1:0 pick width and source, bit 2 the pin edge
    for (int m = 0; m < 8; m++) begin
      wr(3, 8'(((m & 3) << 4) | ((m & 4) << 4)));
      wr(2, 8'($random(seed)));
      if (!ctl[5]) wr(1, 8'(lat));
      wr(0, 8'(lat));
      wr(3, 8'(ctl | 8'h80));
      pins();
      for (int k = 0; k < 6; k++) begin
        wr(3'(k & 1), 8'($random(seed)));
        fire_src(k % 3, 4'h4);
      end
      fire_src(2, 4'h2);
      wr(3, 8'(ctl & 8'h7F));
      pins();
      fire_src(0, 4'h4);
      $display("test mode %0d done", m);
    end
    // mid-run reset: registers hold earlier values, reads must show zeros
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    {hi, lo, pfs, ctl, pl, lat} = 192'h0;
    for (int s = 0; s < 6; s++) rd(3'(s));
    pins();
    wr(2, 8'hFF);
    rd(0);
    rd(1);
    $display("test second reset done");
    complete_run();
  end
endmodule

// file: design/ext_trigger_if.sv
// Purpose: carries the external trigger between control and filter
// Assumes: all signals in the system clock domain
// Notes: edge_sel high selects the rising edge
`timescale 1ns/1ps
interface ext_trigger_if;
  logic raw;
  logic edge_sel;
  logic pulse;
  modport filt (input raw, input edge_sel, output pulse);
  modport ctl (output raw, output edge_sel, input pulse);
endinterface

// file: design/timed_pattern_output.sv
// Purpose: timed pattern output unit with preload buffers and latch
// Assumes: register port single-cycle strobes; timer events one-cycle
// Notes: read data appears the cycle after i_rd
// Functional notes
// - two separate 4-bit halves hold next pattern
// - split mode writes touch only addressed nibble
// - byte mode write loads both halves
// - buffer read returns high then low nibble
// - port-mode bits read as zero
// - reset clears both buffer halves
// - reset clears function select and control
// - latch loaded by hardware only
// - real-time bits ignore port latch writes
// - each function bit picks port or pattern
// - split mode triggers chosen by source select
// - byte mode loads all on one trigger
// - control bits: enable 7, edge 6, width 5, source 4
// - enabled trigger edge copies buffers to latch
// - port-mode bits drive zero on pattern path
// - disabled output drives all pattern pins zero
// - trigger pin needs three equal samples
`timescale 1ns/1ps
module timed_pattern_output (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_timer4_match_event,
  input wire logic i_timer5_match_event,
  input wire logic i_ext_trigger_pin,
  output logic [7:0] o_pattern_output_pins,
  output logic [7:0] o_port_latch
);
  localparam int OE = timed_pattern_pkg::CTRL_OE_BIT;
  localparam int EDG = timed_pattern_pkg::CTRL_EDGE_BIT;
  localparam int WID = timed_pattern_pkg::CTRL_WIDTH_BIT;
  localparam int EXS = timed_pattern_pkg::CTRL_EXT_BIT;

  typedef struct packed {
    logic [3:0] buf_high;
    logic [3:0] buf_low;
    logic [7:0] pin_function_select;
    logic [7:0] output_control;
    logic [7:0] out_latch;
    logic [7:0] port_latch;
    logic [7:0] pins;
    logic [7:0] rdata;
  } rto_s;

  rto_s st_ff;
  rto_s nxt_st;
  ext_trigger_if trg ();
  logic ext_pulse;
  logic oe;
  logic byte_mode;
  logic ext_sel;
  logic load_high;
  logic load_low;
  logic [7:0] buf_view;

  assign trg.raw = i_ext_trigger_pin;
  assign trg.edge_sel = st_ff.output_control[EDG];
  assign ext_pulse = trg.pulse;

  trigger_filter u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .trg(trg)
  );

  assign oe = st_ff.output_control[OE];
  assign byte_mode = st_ff.output_control[WID];
  assign ext_sel = st_ff.output_control[EXS];
  // masked view of both halves for buffer reads
  assign buf_view = {st_ff.buf_high, st_ff.buf_low} &
                    st_ff.pin_function_select;

  // trigger routing; timer events are one-cycle pulses
  always_comb begin
    load_high = 1'b0;
    load_low = 1'b0;
    if (oe) begin
      if (byte_mode) begin
        load_high = ext_sel ? ext_pulse : i_timer4_match_event;
        load_low = load_high;
      end else begin
        load_high = ext_sel ? i_timer4_match_event : i_timer5_match_event;
        load_low = ext_sel ? ext_pulse : i_timer4_match_event;
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = st_ff.rdata;
    // latch samples the buffers as they stood before any write this cycle
    if (load_high) begin
      nxt_st.out_latch[7:4] = st_ff.buf_high;
    end
    if (load_low) begin
      nxt_st.out_latch[3:0] = st_ff.buf_low;
    end
    if (i_wr) begin
      unique case (i_sel)
        timed_pattern_pkg::REG_BUF_LOW: begin
          nxt_st.buf_low = i_wdata[3:0];
          if (byte_mode) begin
            nxt_st.buf_high = i_wdata[7:4];
          end
        end
        timed_pattern_pkg::REG_BUF_HIGH: begin
          // high half keeps bits 7:4 so a read returns what was written
          nxt_st.buf_high = i_wdata[7:4];
          if (byte_mode) begin
            nxt_st.buf_low = i_wdata[3:0];
          end
        end
        timed_pattern_pkg::REG_PIN_FUNC: begin
          nxt_st.pin_function_select = i_wdata;
        end
        timed_pattern_pkg::REG_CONTROL: begin
          nxt_st.output_control = {i_wdata[7:4], 4'h0};
        end
        timed_pattern_pkg::REG_PORT_LATCH: begin
          nxt_st.port_latch =
            (st_ff.port_latch & st_ff.pin_function_select) |
            (i_wdata & ~st_ff.pin_function_select);
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      unique case (i_sel)
        timed_pattern_pkg::REG_BUF_LOW,
        timed_pattern_pkg::REG_BUF_HIGH: begin
          nxt_st.rdata = buf_view;
        end
        timed_pattern_pkg::REG_PIN_FUNC: begin
          nxt_st.rdata = st_ff.pin_function_select;
        end
        timed_pattern_pkg::REG_CONTROL: begin
          nxt_st.rdata = st_ff.output_control;
        end
        timed_pattern_pkg::REG_PORT_LATCH: begin
          nxt_st.rdata = st_ff.port_latch;
        end
        default: begin
          nxt_st.rdata = timed_pattern_pkg::UNMAPPED_READ;
        end
      endcase
    end
    // pins follow the next state so they stay aligned with latch and mode
    nxt_st.pins = nxt_st.output_control[OE] ?
                  (nxt_st.out_latch & nxt_st.pin_function_select) :
                  8'h00;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff.buf_high <= timed_pattern_pkg::BUF_RESET;
      st_ff.buf_low <= timed_pattern_pkg::BUF_RESET;
      st_ff.pin_function_select <= timed_pattern_pkg::PIN_FUNC_RESET;
      st_ff.output_control <= timed_pattern_pkg::CONTROL_RESET;
      st_ff.out_latch <= 8'h00;
      st_ff.port_latch <= timed_pattern_pkg::PORT_LATCH_RESET;
      st_ff.pins <= 8'h00;
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_pattern_output_pins = st_ff.pins;
  assign o_port_latch = st_ff.port_latch;

  a_disabled_pins_zero: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !oe |-> o_pattern_output_pins == 8'h00)
    else $error("pattern pins active while output disabled");

  a_port_bits_zero: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_pattern_output_pins & ~st_ff.pin_function_select) == 8'h00)
    else $error("port-mode bit driven on pattern path");

  a_latch_only_trigger: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(oe && (i_timer4_match_event || i_timer5_match_event || ext_pulse))
    |=> $stable(st_ff.out_latch))
    else $error("output latch changed without a trigger");

  a_byte_timer_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && byte_mode && !ext_sel && i_timer4_match_event
    |=> st_ff.out_latch == $past({st_ff.buf_high, st_ff.buf_low}))
    else $error("byte mode timer4 event did not load latch");

  a_split_high_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && !byte_mode && !ext_sel && i_timer5_match_event
    |=> st_ff.out_latch[7:4] == $past(st_ff.buf_high))
    else $error("split mode timer5 event did not load high half");

  a_split_low_write: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && !byte_mode && i_sel == timed_pattern_pkg::REG_BUF_LOW
    |=> st_ff.buf_low == $past(i_wdata[3:0]) && $stable(st_ff.buf_high))
    else $error("split write to low half disturbed high half");

  a_byte_write_both: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && byte_mode && i_sel == timed_pattern_pkg::REG_BUF_HIGH
    |=> {st_ff.buf_high, st_ff.buf_low} == $past(i_wdata))
    else $error("byte write did not load both halves");

  a_buffer_read_mask: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_rd && (i_sel == timed_pattern_pkg::REG_BUF_LOW ||
             i_sel == timed_pattern_pkg::REG_BUF_HIGH)
    |=> o_rdata == $past({st_ff.buf_high, st_ff.buf_low} &
                         st_ff.pin_function_select))
    else $error("buffer read returned wrong masked value");

  a_port_bit_guard: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && i_sel == timed_pattern_pkg::REG_PORT_LATCH
    |=> (st_ff.port_latch & $past(st_ff.pin_function_select)) ==
        $past(st_ff.port_latch & st_ff.pin_function_select))
    else $error("port latch write changed a pattern-mode bit");

  a_split_high_write: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && !byte_mode && i_sel == timed_pattern_pkg::REG_BUF_HIGH
    |=> st_ff.buf_high == $past(i_wdata[7:4]) && $stable(st_ff.buf_low))
    else $error("split write to high half disturbed low half");

  a_byte_low_write: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && byte_mode && i_sel == timed_pattern_pkg::REG_BUF_LOW
    |=> {st_ff.buf_high, st_ff.buf_low} == $past(i_wdata))
    else $error("byte write to low index did not load both halves");

  a_split_low_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && !byte_mode && !ext_sel && i_timer4_match_event
    |=> st_ff.out_latch[3:0] == $past(st_ff.buf_low))
    else $error("split mode timer4 event did not load low half");

  a_ext_high_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && !byte_mode && ext_sel && i_timer4_match_event
    |=> st_ff.out_latch[7:4] == $past(st_ff.buf_high))
    else $error("split mode timer4 event did not load high half");

  a_ext_low_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && !byte_mode && ext_sel && ext_pulse
    |=> st_ff.out_latch[3:0] == $past(st_ff.buf_low))
    else $error("split mode pin trigger did not load low half");

  a_byte_pin_load: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe && byte_mode && ext_sel && ext_pulse
    |=> st_ff.out_latch == $past({st_ff.buf_high, st_ff.buf_low}))
    else $error("byte mode pin trigger did not load latch");

  a_disabled_latch_hold: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !oe |=> $stable(st_ff.out_latch))
    else $error("output latch loaded while output disabled");

  a_pins_follow_latch: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    oe |-> o_pattern_output_pins ==
           (st_ff.out_latch & st_ff.pin_function_select))
    else $error("pattern pins differ from masked latch");

  a_control_low_zero: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    st_ff.output_control[3:0] == 4'h0)
    else $error("unused control bits are not zero");

  a_rdata_holds: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_rd |=> $stable(o_rdata))
    else $error("read data changed without a read");

  a_func_select_write: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr && i_sel == timed_pattern_pkg::REG_PIN_FUNC
    |=> st_ff.pin_function_select == $past(i_wdata))
    else $error("function select write not stored");
endmodule

// file: design/timed_pattern_pkg.sv
// Purpose: shared constants of the timed pattern output unit
// Assumes: 8-bit register port, one system clock
// Notes: register indexes select a register on the register port
package timed_pattern_pkg;
  localparam int DATA_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int SEL_W = 3;
  // register indexes
  localparam logic [2:0] REG_BUF_LOW = 3'h0;
  localparam logic [2:0] REG_BUF_HIGH = 3'h1;
  localparam logic [2:0] REG_PIN_FUNC = 3'h2;
  localparam logic [2:0] REG_CONTROL = 3'h3;
  localparam logic [2:0] REG_PORT_LATCH = 3'h4;
  // output_control field positions
  localparam int CTRL_OE_BIT = 7;
  localparam int CTRL_EDGE_BIT = 6;
  localparam int CTRL_WIDTH_BIT = 5;
  localparam int CTRL_EXT_BIT = 4;
  // reset values
  localparam logic [3:0] BUF_RESET = 4'h0;
  localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_LATCH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // trigger pin filter: equal samples needed before a level counts
  localparam int FILTER_SAMPLES = 3;
endpackage

// file: design/trigger_filter.sv
// Purpose: sampling noise filter and edge detector for the trigger pin
// Assumes: pin already synchronous to i_sys_clk
// Notes: pulse is one cycle, registered
`timescale 1ns/1ps
module trigger_filter (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  ext_trigger_if.filt trg
);
  localparam int N = timed_pattern_pkg::FILTER_SAMPLES;

  typedef struct packed {
    logic [N-1:0] samples;
    logic level;
    logic pulse;
  } filt_s;

  filt_s st_ff;
  filt_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.samples = {st_ff.samples[N-2:0], trg.raw};
    nxt_st.pulse = 1'b0;
    // a level counts only once every sample agrees with it
    if ((&st_ff.samples || ~|st_ff.samples) &&
        st_ff.samples[0] != st_ff.level) begin
      nxt_st.level = st_ff.samples[0];
      nxt_st.pulse = (st_ff.samples[0] == trg.edge_sel);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign trg.pulse = st_ff.pulse;

  a_filter_needs_three: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    trg.pulse |-> ($past(trg.raw, 2) == $past(trg.raw, 3)) &&
                  ($past(trg.raw, 3) == $past(trg.raw, 4)))
    else $error("trigger accepted without three equal samples");

  a_edge_direction: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    trg.pulse |-> $past(trg.raw, 2) == $past(trg.edge_sel))
    else $error("trigger edge does not match selected direction");
endmodule
